// ---- design/mmst_sync.sv ----
// Three-stage synchroniser with agreement filter for a vector of pins.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module mmst_sync #(
	parameter int         W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] o;
	} mmst_sync_state_type;

	mmst_sync_state_type q;
	mmst_sync_state_type d;

	// ****************************************
	// Agreement filter per bit
	// ****************************************
	always_comb begin
		d    = q;
		d.s1 = pinIn;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.o[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, o: RST_VAL};
		end else begin
			q <= d;
		end
	end

	assign pinOut = q.o;

endmodule : mmst_sync

`default_nettype wire

// ---- design/mmst_top.sv ----
// Management status sequencing: init, reset pin, interrupt flags, masks, power.
// Assumes a bus engine on clk that pulses read and write stop events.
`timescale 1ns/1ps
`default_nettype none

module mmst_top #(
	parameter int NF          = mmst_pkg::NUM_FLAGS,
	parameter int INIT_CYCLES = mmst_pkg::INIT_CYC
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          busClk,
	input  wire logic          moduleResetN,
	input  wire logic          lowPowerSelect,
	input  wire logic          moduleSelectN,
	input  wire logic [NF-1:0] flagCond,
	input  wire logic          rdStop,
	input  wire logic [NF:0]   rdClearMask,
	input  wire logic          wrStop,
	input  wire logic [NF-1:0] wrMask,
	input  wire logic          wrPdown,
	output logic               irqOutN,
	output logic               busRespondEn,
	output logic               lowPower,
	output logic               dataNotReady,
	output logic               readyFlag,
	output logic      [NF-1:0] flagsOut,
	output logic      [NF-1:0] maskOut,
	output logic               pdownOut
);

	localparam int PW = NF + mmst_pkg::PIN_COND;
	localparam logic [PW-1:0] PIN_RST = PW'(32'h0000_000B);
	localparam logic [7:0] RST_MIN8 = 8'(mmst_pkg::RESET_MIN_CYC);
	localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);

	typedef struct packed {
		mmst_pkg::mmst_state_type state;
		logic [31:0]              initCnt;
		logic [7:0]               rstCnt;
		logic                     busClkPrev;
		logic                     pendRd;
		logic [NF:0]              pendClr;
		logic                     pendWr;
		logic [NF-1:0]            pendMask;
		logic                     pendPd;
		logic [NF-1:0]            flags;
		logic                     readyFlag;
		logic [NF-1:0]            mask;
		logic                     pdown;
		logic                     dnr;
		logic                     irqN;
		logic                     resp;
		logic                     lowPwr;
	} mmst_top_state_type;

	localparam mmst_top_state_type RESET_STATE = '{
		state: mmst_pkg::ST_INIT, busClkPrev: 1'b1, dnr: 1'b1, irqN: 1'b1, default: '0
	};

	mmst_top_state_type q;
	mmst_top_state_type d;
	logic [PW-1:0]      pinS;
	logic               busFall;
	logic               rstReq;
	logic               running;
	logic [NF:0]        clrNow;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	mmst_sync #(
		.W       (PW),
		.RST_VAL (PIN_RST)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pinIn   ({flagCond, moduleSelectN, lowPowerSelect, moduleResetN, busClk}),
		.pinOut  (pinS)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d            = q;
		running      = (q.state == mmst_pkg::ST_RUN);
		busFall      = q.busClkPrev & ~pinS[mmst_pkg::PIN_BCLK];
		d.busClkPrev = pinS[mmst_pkg::PIN_BCLK];
		clrNow       = '0;
		// Low reset pin counted, saturating at the minimum pulse
		if (!pinS[mmst_pkg::PIN_RSTN]) begin
			if (q.rstCnt != RST_MIN8) begin
				d.rstCnt = q.rstCnt + 8'h01;
			end
		end else begin
			d.rstCnt = 8'h00;
		end
		rstReq = (q.rstCnt == RST_MIN8);
		if (rstReq) begin
			d = RESET_STATE;
			d.rstCnt     = d.rstCnt | ((pinS[mmst_pkg::PIN_RSTN]) ? 8'h00 : RST_MIN8);
			d.busClkPrev = pinS[mmst_pkg::PIN_BCLK];
		end else begin
			case (q.state)
				mmst_pkg::ST_INIT: begin
					// Init ends with data ready and the ready event latched
					if (q.initCnt == INIT_LAST) begin
						d.state     = mmst_pkg::ST_RUN;
						d.dnr       = 1'b0;
						d.readyFlag = 1'b1;
					end else begin
						d.initCnt = q.initCnt + 32'h0000_0001;
					end
				end
				mmst_pkg::ST_RUN: begin
					// Pending actions take effect at the first bus clock fall
					if (busFall && q.pendRd) begin
						clrNow   = q.pendClr;
						d.pendRd = 1'b0;
					end
					if (busFall && q.pendWr) begin
						d.mask   = q.pendMask;
						d.pdown  = q.pendPd;
						d.pendWr = 1'b0;
					end
					if (rdStop) begin
						d.pendRd  = 1'b1;
						d.pendClr = rdClearMask;
					end
					if (wrStop) begin
						d.pendWr   = 1'b1;
						d.pendMask = wrMask;
						d.pendPd   = wrPdown;
					end
					// Set wins over clear; flags hold until read
					d.flags = (q.flags & ~clrNow[NF-1:0]) | pinS[PW-1:mmst_pkg::PIN_COND];
					d.readyFlag = q.readyFlag & ~clrNow[NF];
				end
				default: begin
					d.state = mmst_pkg::ST_INIT;
				end
			endcase
		end
		// Registered pin-facing outputs
		d.irqN   = ~(running && ((|(q.flags & ~q.mask)) || q.readyFlag));
		d.resp   = running && !pinS[mmst_pkg::PIN_SELN] && !rstReq;
		d.lowPwr = pinS[mmst_pkg::PIN_LP] | q.pdown;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign irqOutN      = q.irqN;
	assign busRespondEn = q.resp;
	assign lowPower     = q.lowPwr;
	assign dataNotReady = q.dnr;
	assign readyFlag    = q.readyFlag;
	assign flagsOut     = q.flags;
	assign maskOut      = q.mask;
	assign pdownOut     = q.pdown;

	// ****************************************
	// Checks
	// ****************************************
	chk_init_bound: assert property (@(posedge clk) disable iff (sys_rst)
		(q.state == mmst_pkg::ST_INIT) |-> (q.initCnt <= INIT_LAST))
		else $error("init counter passed its limit");

	chk_reset_pin: assert property (@(posedge clk) disable iff (sys_rst)
		(q.rstCnt == RST_MIN8) |=> (q.state == mmst_pkg::ST_INIT && q.dnr && !q.resp))
		else $error("long reset pulse not taken as reset");

	chk_ready_irq: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(q.dnr) |-> q.readyFlag ##1 !q.irqN)
		else $error("ready event did not assert interrupt");

	chk_lowpower_pin: assert property (@(posedge clk) disable iff (sys_rst)
		pinS[mmst_pkg::PIN_LP] |=> q.lowPwr)
		else $error("low power select not followed");

	chk_flag_latch: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && pinS[mmst_pkg::PIN_COND]) |=> q.flags[mmst_pkg::FLAG_LOS] ##1
		(!$past(q.mask[0]) -> !q.irqN))
		else $error("loss flag or interrupt missing");

	chk_irq_release: assert property (@(posedge clk) disable iff (sys_rst)
		(((q.flags & ~q.mask) == '0) && !q.readyFlag) |=> q.irqN)
		else $error("interrupt held with no unmasked flag");

	chk_select_answer: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && !pinS[mmst_pkg::PIN_SELN]) |=> q.resp)
		else $error("selected module not answering");

	chk_deselect_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		pinS[mmst_pkg::PIN_SELN] |=> !q.resp)
		else $error("deselected module still answering");

	chk_write_on_fall: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && busFall && q.pendWr && !wrStop) |=> (q.mask == $past(q.pendMask) && !q.pendWr))
		else $error("write not applied at bus clock fall");

	chk_write_waits: assert property (@(posedge clk) disable iff (sys_rst)
		(wrStop && !busFall && running && !rstReq) |=> $stable(q.mask))
		else $error("mask changed before bus clock fall");

	chk_pdown_power: assert property (@(posedge clk) disable iff (sys_rst)
		q.pdown |=> q.lowPwr)
		else $error("power-down bit not honoured");

	// ****************************************
	// Checks: init and reset pin
	// ****************************************
	chk_init_count: assert property (@(posedge clk) disable iff (sys_rst)
		(q.state == mmst_pkg::ST_INIT && !rstReq && q.initCnt != INIT_LAST) |=>
		(q.initCnt == $past(q.initCnt) + 32'h0000_0001))
		else $error("init counter did not advance");

	chk_dnr_state: assert property (@(posedge clk) disable iff (sys_rst)
		q.dnr == (q.state == mmst_pkg::ST_INIT))
		else $error("data-not-ready out of step with state");

	chk_init_irq: assert property (@(posedge clk) disable iff (sys_rst)
		(q.state == mmst_pkg::ST_INIT) |=> q.irqN)
		else $error("interrupt asserted during init");

	chk_init_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!running |=> !q.resp)
		else $error("bus answered before init done");

	chk_reset_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(!pinS[mmst_pkg::PIN_RSTN] && q.rstCnt == RST_MIN8) |=> (q.rstCnt == RST_MIN8))
		else $error("reset not held while pin low");

	chk_short_reset: assert property (@(posedge clk) disable iff (sys_rst)
		(q.rstCnt != RST_MIN8 && q.state == mmst_pkg::ST_RUN) |=> (q.state == mmst_pkg::ST_RUN))
		else $error("short reset pulse restarted init");

	// ****************************************
	// Checks: flags and interrupt
	// ****************************************
	chk_txf_latch: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && pinS[mmst_pkg::PIN_COND + mmst_pkg::FLAG_TXF]) |=> q.flags[mmst_pkg::FLAG_TXF])
		else $error("transmit fault flag not latched");

	chk_other_latch: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && pinS[mmst_pkg::PIN_COND + mmst_pkg::FLAG_OTHER]) |=> q.flags[mmst_pkg::FLAG_OTHER])
		else $error("other flag not latched");

	chk_irq_assert: assert property (@(posedge clk) disable iff (sys_rst)
		(running && ((q.flags & ~q.mask) != '0)) |=> !q.irqN)
		else $error("unmasked flag without interrupt");

	chk_mask_inhibit: assert property (@(posedge clk) disable iff (sys_rst)
		(q.mask == {NF{1'b1}} && !q.readyFlag) |=> q.irqN)
		else $error("masked flag drove interrupt");

	chk_mask_resume: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !q.mask[mmst_pkg::FLAG_OTHER] && q.flags[mmst_pkg::FLAG_OTHER]) |=> !q.irqN)
		else $error("unmasked flag did not resume interrupt");

	chk_ready_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && busFall && q.pendRd && q.pendClr[NF]) |=> !q.readyFlag)
		else $error("ready event not cleared by read");

	chk_los_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && busFall && q.pendRd && q.pendClr[mmst_pkg::FLAG_LOS] &&
		!pinS[mmst_pkg::PIN_COND]) |=> !q.flags[mmst_pkg::FLAG_LOS])
		else $error("loss flag not cleared by read");

	chk_clear_waits: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && !busFall) |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
		else $error("flag cleared before bus clock fall");

	// ****************************************
	// Checks: bus events and power
	// ****************************************
	chk_pend_read: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && rdStop) |=> q.pendRd)
		else $error("read stop not held pending");

	chk_read_on_fall: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && busFall && q.pendRd && !rdStop) |=> !q.pendRd)
		else $error("pending read not applied at bus clock fall");

	chk_pend_write: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && wrStop) |=> q.pendWr)
		else $error("write stop not held pending");

	chk_write_pdown: assert property (@(posedge clk) disable iff (sys_rst)
		(running && !rstReq && busFall && q.pendWr && !wrStop) |=> (q.pdown == $past(q.pendPd)))
		else $error("power-down bit not applied at bus clock fall");

	chk_lowpower_exit: assert property (@(posedge clk) disable iff (sys_rst)
		(!pinS[mmst_pkg::PIN_LP] && !q.pdown) |=> !q.lowPwr)
		else $error("lower power held with no request");

endmodule : mmst_top

`default_nettype wire

// ---- pkg/mmst_pkg.sv ----
// Constants for the module management status and timing block.
// Assumes a single 50 MHz system clock and an outside two-wire bus engine.

package mmst_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ        = 50_000_000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_MIN_NS  = 2000;
	localparam int INIT_MS       = 2000;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYC      = INIT_MS * (CLK_HZ / 1000);

	// ****************************************
	// Pin vector layout after synchronising
	// ****************************************
	localparam int NUM_FLAGS  = 3;
	localparam int FLAG_LOS   = 0;
	localparam int FLAG_TXF   = 1;
	localparam int FLAG_OTHER = 2;
	localparam int PIN_BCLK   = 0;
	localparam int PIN_RSTN   = 1;
	localparam int PIN_LP     = 2;
	localparam int PIN_SELN   = 3;
	localparam int PIN_COND   = 4;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [0:0] {
		ST_INIT,
		ST_RUN
	} mmst_state_type;

endpackage : mmst_pkg

// ---- tb/mmst_bench.sv ----
// Bench for the management status block with a host model.
// Assumes a short init count so the run stays brief.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[ERR] %s exp=%h got=%h", nm, exp, got); end end

module mmst_bench;
	logic       clk = 1'h0;
	logic       sys_rst = 1'h1;
	logic       moduleResetN = 1'h1;
	logic       lowPowerSelect = 1'h0;
	logic       moduleSelectN = 1'h0;
	logic [2:0] flagCond = 3'h0;
	logic       busClk, rdStop, wrStop, wrPdown, irqOutN, busRespondEn, lowPower;
	logic       dataNotReady, readyFlag, pdownOut;
	logic [3:0] rdClearMask;
	logic [2:0] wrMask, flagsOut, maskOut;
	int         error_cnt = 0;
	int         samples_checked = 0;

	always #10 clk = ~clk;

	mmst_host_model #(.NF(3)) i_mmst_host_model (.clk(clk), .busClk(busClk), .rdStop(rdStop),
		.rdClearMask(rdClearMask), .wrStop(wrStop), .wrMask(wrMask), .wrPdown(wrPdown));
	mmst_top #(.NF(3), .INIT_CYCLES(50)) i_mmst_top (.clk(clk), .sys_rst(sys_rst), .busClk(busClk),
		.moduleResetN(moduleResetN), .lowPowerSelect(lowPowerSelect), .moduleSelectN(moduleSelectN),
		.flagCond(flagCond), .rdStop(rdStop), .rdClearMask(rdClearMask), .wrStop(wrStop),
		.wrMask(wrMask), .wrPdown(wrPdown), .irqOutN(irqOutN), .busRespondEn(busRespondEn),
		.lowPower(lowPower), .dataNotReady(dataNotReady), .readyFlag(readyFlag),
		.flagsOut(flagsOut), .maskOut(maskOut), .pdownOut(pdownOut));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic waitv(ref logic s, input logic v);
		int n;
		n = 0;
		@(negedge clk);
		while (s !== v && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (s !== v) begin
			error_cnt++;
			$display("[ERR] waitLimit exp=%h got=%h", v, s);
		end
	endtask : waitv

	task automatic give_verdict();
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_init();
		@(negedge clk);
		`CHK("notReady", 1'h1, dataNotReady)
		waitv(dataNotReady, 1'h0);
		`CHK("readyFlag", 1'h1, readyFlag)
		waitv(irqOutN, 1'h0);
		`CHK("irqInit", 1'h0, irqOutN)
		`CHK("respond", 1'h1, busRespondEn)
		i_mmst_host_model.xfer(1'h1, 4'h8, 3'h0, 1'h0);
		waitv(irqOutN, 1'h1);
		`CHK("readyClr", 1'h0, readyFlag)
	endtask : t_init

	task automatic t_flags();
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			flagCond <= 3'h1 << i;
			waitv(irqOutN, 1'h0);
			`CHK("flagSet", 3'h1 << i, flagsOut)
			@(posedge clk);
			flagCond <= 3'h0;
			i_mmst_host_model.xfer(1'h1, 4'h1 << i, 3'h0, 1'h0);
			waitv(irqOutN, 1'h1);
			`CHK("flagClr", 4'h0, {irqOutN, flagsOut} ^ 4'h8)
		end
	endtask : t_flags

	task automatic t_multi();
		@(posedge clk);
		flagCond <= 3'h3;
		repeat (40) @(posedge clk);
		flagCond <= 3'h0;
		i_mmst_host_model.xfer(1'h1, 4'h1, 3'h0, 1'h0);
		repeat (40) @(negedge clk);
		`CHK("irqHeld", 4'h2, {irqOutN, flagsOut})
		i_mmst_host_model.xfer(1'h1, 4'h2, 3'h0, 1'h0);
		waitv(irqOutN, 1'h1);
		`CHK("irqFree", 1'h1, irqOutN)
	endtask : t_multi

	task automatic t_mask();
		i_mmst_host_model.xfer(1'h0, 4'h0, 3'h7, 1'h0);
		repeat (40) @(negedge clk);
		`CHK("mask", 3'h7, maskOut)
		@(posedge clk);
		flagCond <= 3'h4;
		repeat (40) @(negedge clk);
		`CHK("masked", 4'hc, {irqOutN, flagsOut})
		@(posedge clk);
		flagCond <= 3'h0;
		i_mmst_host_model.xfer(1'h0, 4'h0, 3'h0, 1'h0);
		waitv(irqOutN, 1'h0);
		`CHK("unmasked", 1'h0, irqOutN)
		i_mmst_host_model.xfer(1'h1, 4'h4, 3'h0, 1'h0);
		waitv(irqOutN, 1'h1);
	endtask : t_mask

	task automatic t_power();
		@(posedge clk);
		lowPowerSelect <= 1'h1;
		waitv(lowPower, 1'h1);
		`CHK("lpPin", 1'h1, lowPower)
		@(posedge clk);
		lowPowerSelect <= 1'h0;
		waitv(lowPower, 1'h0);
		i_mmst_host_model.xfer(1'h0, 4'h0, 3'h0, 1'h1);
		waitv(lowPower, 1'h1);
		`CHK("pdown", 2'h3, {lowPower, pdownOut})
		i_mmst_host_model.xfer(1'h0, 4'h0, 3'h0, 1'h0);
		waitv(lowPower, 1'h0);
		`CHK("pdownOff", 2'h0, {lowPower, pdownOut})
	endtask : t_power

	task automatic t_select();
		@(posedge clk);
		moduleSelectN <= 1'h1;
		waitv(busRespondEn, 1'h0);
		`CHK("deselect", 1'h0, busRespondEn)
		@(posedge clk);
		moduleSelectN <= 1'h0;
		waitv(busRespondEn, 1'h1);
		`CHK("select", 1'h1, busRespondEn)
	endtask : t_select

	task automatic t_modreset();
		@(posedge clk);
		moduleResetN <= 1'h0;
		repeat (50) @(posedge clk);
		moduleResetN <= 1'h1;
		repeat (20) @(negedge clk);
		`CHK("shortRst", 1'h0, dataNotReady)
		@(posedge clk);
		moduleResetN <= 1'h0;
		repeat (120) @(negedge clk);
		`CHK("longRst", 1'h1, dataNotReady)
		@(posedge clk);
		moduleResetN <= 1'h1;
		waitv(irqOutN, 1'h0);
		`CHK("reinit", 2'h1, {irqOutN, readyFlag})
	endtask : t_modreset

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'h0;
		t_init();
		t_flags();
		t_multi();
		t_mask();
		t_power();
		t_select();
		t_modreset();
		give_verdict();
	end

	initial begin
		#300us;
		error_cnt++;
		give_verdict();
	end
endmodule : mmst_bench

`default_nettype wire

// ---- tb/mmst_host_model.sv ----
// Host model: bus clock frames plus stop events of reads and writes.
// Assumes the bench clk; bus clock runs at 160 ns only inside frames.
`timescale 1ns/1ps
`default_nettype none

module mmst_host_model #(
	parameter int NF = 3
) (
	input  wire logic          clk,
	output logic               busClk,
	output logic               rdStop,
	output logic      [NF:0]   rdClearMask,
	output logic               wrStop,
	output logic      [NF-1:0] wrMask,
	output logic               wrPdown
);
	initial begin
		busClk      = 1'h1;
		rdStop      = 1'h0;
		wrStop      = 1'h0;
		rdClearMask = '0;
		wrMask      = '0;
		wrPdown     = 1'h0;
	end

	// ****************************************
	// One transfer: stop, then falling bus clock edges
	// ****************************************
	task automatic xfer(input logic isRd, input logic [NF:0] clr, input logic [NF-1:0] m, input logic p);
		@(posedge clk);
		rdStop      <= isRd;
		wrStop      <= ~isRd;
		rdClearMask <= clr;
		wrMask      <= m;
		wrPdown     <= p;
		@(posedge clk);
		rdStop      <= 1'h0;
		wrStop      <= 1'h0;
		rdClearMask <= ~clr;
		wrMask      <= ~m;
		wrPdown     <= ~p;
		#10;
		repeat (2) begin
			#80 busClk = 1'h0;
			#80 busClk = 1'h1;
		end
	endtask : xfer
endmodule : mmst_host_model

`default_nettype wire
